/* File: rtl/pmlc_map.svh */
`ifndef PMLC_MAP_SVH
`define PMLC_MAP_SVH

// ----------------------------------------------------------------
// management register offsets
// ----------------------------------------------------------------
`define PMLC_ADDR_BMC 16'h0000
`define PMLC_ADDR_GC1 16'h0009
`define PMLC_ADDR_STL 16'h0016
`define PMLC_ADDR_XOC 16'h0019
`define PMLC_ADDR_FGC 16'h0465

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PMLC_BMC_SOFTRST 15
`define PMLC_BMC_LOOPMII 14
`define PMLC_BMC_SPEED 13
`define PMLC_BMC_ANEN 12
`define PMLC_GC1_FASTX 6
`define PMLC_STL_PCSIN 0
`define PMLC_STL_PCSOUT 1
`define PMLC_STL_DIGITAL 2
`define PMLC_STL_ANALOG 3
`define PMLC_XOC_AUTO 15
`define PMLC_XOC_FORCE 14
`define PMLC_XOC_RESOLVED 5
`define PMLC_XOC_MDIX 4
`define PMLC_FGC_SDPOL 0
`define PMLC_FGC_FAULT 1

// ----------------------------------------------------------------
// reset values and strap levels
// ----------------------------------------------------------------
`define PMLC_BMC_RST 16'h2000
`define PMLC_ZERO_RST 16'h0000
`define PMLC_STRAP_L2 2'h1
`define PMLC_STRAP_L3 2'h2
`define PMLC_STRAP_L4 2'h3
`define PMLC_STRAP_SETTLE 3'h4

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PMLC_CLK_NS 50
`define PMLC_SQ_GAP_NS 50
`define PMLC_SQ_GAP_CYC ((`PMLC_SQ_GAP_NS + `PMLC_CLK_NS - 1) / `PMLC_CLK_NS)
`define PMLC_SQ_QUIET_CYC 8
`define PMLC_NLP_W_NS 100
`define PMLC_NLP_W_CYC (`PMLC_NLP_W_NS / `PMLC_CLK_NS)
`define PMLC_NLP_MS 16
`define PMLC_NLP_CYC (`PMLC_NLP_MS * 1000000 / `PMLC_CLK_NS)
`define PMLC_JAB_MS 100
`define PMLC_JAB_CYC (`PMLC_JAB_MS * 1000000 / `PMLC_CLK_NS)
`define PMLC_UNJAB_MS 500
`define PMLC_UNJAB_CYC (`PMLC_UNJAB_MS * 1000000 / `PMLC_CLK_NS)
`define PMLC_XSLOT_SLOW 1000
`define PMLC_XSLOT_FAST 250

`endif

/* File: rtl/pmlc_pkg.sv */
package pmlc_pkg;
  typedef enum logic [1:0] {
    SQ_IDLE = 2'h0,
    SQ_QUAL = 2'h1,
    SQ_VALID = 2'h3
  } pmlc_sq_state_t;
endpackage

/* File: rtl/pmlc_squelch.sv */
`timescale 1ns/1ns
`include "pmlc_map.svh"
module pmlc_squelch (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic posCross,
  input wire logic negCross,
  input wire logic txActive,
  output logic rxValid
);
  pmlc_pkg::pmlc_sq_state_t state_q;
  logic expectPos_q;
  logic [2:0] tran_q;
  logic [3:0] gap_q;
  logic [3:0] quiet_q;
  logic rxValid_q;
  logic anyCross;
  logic rightCross;
  logic [2:0] need;

  assign anyCross = posCross | negCross;
  assign rightCross = expectPos_q ? posCross : negCross;
  assign need = txActive ? 3'h5 : 3'h3;
  assign rxValid = rxValid_q;

  // ----------------------------------------------------------------
  // qualification
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= pmlc_pkg::SQ_IDLE;
      expectPos_q <= 1'b0;
      tran_q <= 3'h0;
      gap_q <= 4'h0;
    end else begin
      gap_q <= (gap_q == 4'hf) ? gap_q : gap_q + 4'h1;
      case (state_q)
        pmlc_pkg::SQ_IDLE: begin
          if (anyCross) begin
            state_q <= pmlc_pkg::SQ_QUAL;
            expectPos_q <= negCross;
            tran_q <= 3'h1;
            gap_q <= 4'h0;
          end
        end
        pmlc_pkg::SQ_QUAL: begin
          if (anyCross) begin
            gap_q <= 4'h0;
            // too early or same polarity twice: reject the waveform
            if (!rightCross || gap_q < 4'(`PMLC_SQ_GAP_CYC - 1)) begin
              state_q <= pmlc_pkg::SQ_IDLE;
            end else if (tran_q + 3'h1 == need) begin
              // under transmit the circuit rearms after five
              state_q <= txActive ? pmlc_pkg::SQ_IDLE : pmlc_pkg::SQ_VALID;
            end else begin
              tran_q <= tran_q + 3'h1;
              expectPos_q <= ~expectPos_q;
            end
          end
        end
        pmlc_pkg::SQ_VALID: begin
          if (quiet_q == 4'(`PMLC_SQ_QUIET_CYC)) begin
            state_q <= pmlc_pkg::SQ_IDLE;
          end
        end
        default: state_q <= pmlc_pkg::SQ_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // valid flag, dropped once the line goes quiet
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxValid_q <= 1'b0;
      quiet_q <= 4'h0;
    end else begin
      quiet_q <= anyCross ? 4'h0 :
                 (quiet_q == 4'hf ? quiet_q : quiet_q + 4'h1);
      if (state_q == pmlc_pkg::SQ_QUAL && anyCross && rightCross &&
          gap_q >= 4'(`PMLC_SQ_GAP_CYC - 1) && tran_q + 3'h1 == need) begin
        rxValid_q <= 1'b1;
      end else if (quiet_q == 4'(`PMLC_SQ_QUIET_CYC)) begin
        rxValid_q <= 1'b0;
      end
    end
  end

  sequence s_two_steps;
    state_q == pmlc_pkg::SQ_QUAL && tran_q == 3'h2;
  endsequence
  property p_sq_three;
    @(posedge clk) disable iff (!rst_n)
      s_two_steps ##0 (!txActive && anyCross && rightCross) |=> rxValid_q;
  endproperty
  a_sq_three: assert property (p_sq_three)
    else $error("third qualified crossing did not flag valid data");

  property p_sq_tx_rearm;
    @(posedge clk) disable iff (!rst_n)
      (state_q == pmlc_pkg::SQ_QUAL && tran_q == 3'h4 && txActive &&
       rightCross) |=> (rxValid_q && state_q == pmlc_pkg::SQ_IDLE);
  endproperty
  a_sq_tx_rearm: assert property (p_sq_tx_rearm)
    else $error("fifth transition under transmit did not qualify and rearm");
endmodule

/* File: rtl/pmlc_jabber.sv */
`timescale 1ns/1ns
module pmlc_jabber #(
  parameter int unsigned JAB_CYC = 2000000,
  parameter int unsigned UNJAB_CYC = 10000000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic txEnable,
  input wire logic speed10,
  output logic txDisable
);
  logic jabbed_q;
  logic [23:0] actCnt_q;
  logic [23:0] offCnt_q;

  assign txDisable = jabbed_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      jabbed_q <= 1'b0;
      actCnt_q <= 24'h0;
      offCnt_q <= 24'h0;
    end else if (!speed10) begin
      // lockout never acts at 100 Mbps
      jabbed_q <= 1'b0;
      actCnt_q <= 24'h0;
      offCnt_q <= 24'h0;
    end else if (!jabbed_q) begin
      offCnt_q <= 24'h0;
      if (!txEnable) begin
        actCnt_q <= 24'h0;
      end else if (actCnt_q == 24'(JAB_CYC - 1)) begin
        jabbed_q <= 1'b1;
      end else begin
        actCnt_q <= actCnt_q + 24'h1;
      end
    end else begin
      actCnt_q <= 24'h0;
      if (txEnable) begin
        offCnt_q <= 24'h0;
      end else if (offCnt_q == 24'(UNJAB_CYC - 1)) begin
        jabbed_q <= 1'b0;
      end else begin
        offCnt_q <= offCnt_q + 24'h1;
      end
    end
  end

  property p_jab_hold;
    @(posedge clk) disable iff (!rst_n)
      (jabbed_q && txEnable && speed10) |=> jabbed_q;
  endproperty
  a_jab_hold: assert property (p_jab_hold)
    else $error("jabber released while transmit enable still high");

  property p_jab_fast;
    @(posedge clk) disable iff (!rst_n)
      !speed10 |=> !txDisable;
  endproperty
  a_jab_fast: assert property (p_jab_fast)
    else $error("jabber lockout active at 100 Mbps");
endmodule

/* File: rtl/pmlc_top.sv */
`timescale 1ns/1ns
`include "pmlc_map.svh"
module pmlc_top #(
  parameter int unsigned NLP_CYC = `PMLC_NLP_CYC,
  parameter int unsigned JAB_CYC = `PMLC_JAB_CYC,
  parameter int unsigned UNJAB_CYC = `PMLC_UNJAB_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] fiberModeStrap,
  input wire logic [1:0] autoCrossoverStrap,
  input wire logic autonegStrap,
  input wire logic fiberSignalDetectPin,
  input wire logic fiberLinkFault,
  input wire logic sqPosCross,
  input wire logic sqNegCross,
  input wire logic nlpSeen,
  input wire logic nlpNegFirst,
  input wire logic txEnable,
  input wire logic energyDetected,
  input wire logic partnerPageValid,
  input wire logic [1:0] partnerAbility,
  input wire logic [15:0] mgmtAddr,
  input wire logic [15:0] mgmtWrData,
  input wire logic mgmtWrEn,
  input wire logic mgmtRdEn,
  output logic [15:0] mgmtRdData,
  output logic txBypassScramble,
  output logic rxBypassDescramble,
  output logic fiberSignalDetectEn,
  output logic fiberLinkUp,
  output logic rxDataValid,
  output logic linkPulseOut,
  output logic txDisable,
  output logic rxPolarityInvert,
  output logic autonegActive,
  output logic speed100,
  output logic mdixSelect,
  output logic loopMii,
  output logic loopPcsIn,
  output logic loopPcsOut,
  output logic loopDigital,
  output logic loopAnalog
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] pinRaw;
  logic [7:0] pinS1_q;
  logic [7:0] pinS2_q;
  logic [7:0] pinS3_q;
  logic [7:0] pinF_q;
  logic sqPosPrev_q;
  logic sqNegPrev_q;

  assign pinRaw = {fiberModeStrap, autoCrossoverStrap, autonegStrap,
                   fiberSignalDetectPin, sqPosCross, sqNegCross};

  // a bit moves only once stages two and three agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinS1_q <= 8'h00;
      pinS2_q <= 8'h00;
      pinS3_q <= 8'h00;
      pinF_q <= 8'h00;
      sqPosPrev_q <= 1'b0;
      sqNegPrev_q <= 1'b0;
    end else begin
      pinS1_q <= pinRaw;
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
      pinF_q <= (pinS2_q & pinS3_q) | (pinF_q & (pinS2_q | pinS3_q));
      sqPosPrev_q <= pinF_q[1];
      sqNegPrev_q <= pinF_q[0];
    end
  end

  // ----------------------------------------------------------------
  // straps, caught once the synchronisers have settled
  // ----------------------------------------------------------------
  logic [2:0] settle_q;
  logic strapTaken_q;
  logic fiberMode_q;
  logic sdEn_q;
  logic crossStrapOn_q;
  logic anStrap_q;
  logic strapLoad;

  assign strapLoad = !strapTaken_q && settle_q == `PMLC_STRAP_SETTLE;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      settle_q <= 3'h0;
      strapTaken_q <= 1'b0;
      fiberMode_q <= 1'b0;
      sdEn_q <= 1'b0;
      crossStrapOn_q <= 1'b0;
      anStrap_q <= 1'b0;
    end else if (!strapTaken_q) begin
      settle_q <= settle_q + 3'h1;
      if (strapLoad) begin
        strapTaken_q <= 1'b1;
        fiberMode_q <= pinF_q[7:6] == `PMLC_STRAP_L2 ||
                       pinF_q[7:6] == `PMLC_STRAP_L3;
        // the crossover strap doubles as detect enable in fiber
        sdEn_q <= (pinF_q[7:6] == `PMLC_STRAP_L2 ||
                   pinF_q[7:6] == `PMLC_STRAP_L3) &&
                  (pinF_q[5:4] == `PMLC_STRAP_L3 ||
                   pinF_q[5:4] == `PMLC_STRAP_L4);
        crossStrapOn_q <= pinF_q[5:4] != 2'h0;
        anStrap_q <= pinF_q[3];
      end
    end
  end

  // ----------------------------------------------------------------
  // management registers
  // ----------------------------------------------------------------
  logic [15:0] bmc_q;
  logic [15:0] gc1_q;
  logic [15:0] stl_q;
  logic [15:0] xoc_q;
  logic [15:0] fgc_q;
  logic [15:0] rdData_q;
  logic softReset_q;
  logic faultLatched_q;
  logic mdix_q;
  logic mdixDone_q;
  logic loadDefaults;

  function automatic logic wrHit(input logic [15:0] a);
    wrHit = mgmtWrEn && mgmtAddr == a;
  endfunction

  // soft reset reapplies the strap-derived defaults
  assign loadDefaults = strapLoad || softReset_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bmc_q <= `PMLC_BMC_RST;
      gc1_q <= `PMLC_ZERO_RST;
      stl_q <= `PMLC_ZERO_RST;
      xoc_q <= `PMLC_ZERO_RST;
      fgc_q <= `PMLC_ZERO_RST;
      softReset_q <= 1'b0;
    end else begin
      softReset_q <= wrHit(`PMLC_ADDR_BMC) && mgmtWrData[`PMLC_BMC_SOFTRST];
      if (loadDefaults) begin
        bmc_q <= `PMLC_BMC_RST;
        bmc_q[`PMLC_BMC_ANEN] <= strapLoad ? pinF_q[3] : anStrap_q;
        gc1_q <= `PMLC_ZERO_RST;
        stl_q <= `PMLC_ZERO_RST;
        xoc_q <= `PMLC_ZERO_RST;
        xoc_q[`PMLC_XOC_AUTO] <= strapLoad ? pinF_q[5:4] != 2'h0 :
                                 crossStrapOn_q;
        fgc_q <= `PMLC_ZERO_RST;
      end else begin
        if (wrHit(`PMLC_ADDR_BMC)) begin
          bmc_q <= {1'b0, mgmtWrData[14:0]};
        end
        if (wrHit(`PMLC_ADDR_GC1)) begin
          gc1_q <= mgmtWrData;
        end
        if (wrHit(`PMLC_ADDR_STL)) begin
          stl_q <= mgmtWrData;
        end
        if (wrHit(`PMLC_ADDR_XOC)) begin
          xoc_q <= mgmtWrData;
        end
        if (wrHit(`PMLC_ADDR_FGC)) begin
          fgc_q <= mgmtWrData;
        end
      end
    end
  end

  // status bits read back in place of the stored ones
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdData_q <= 16'h0000;
    end else if (mgmtRdEn) begin
      case (mgmtAddr)
        `PMLC_ADDR_BMC: rdData_q <= bmc_q;
        `PMLC_ADDR_GC1: rdData_q <= gc1_q;
        `PMLC_ADDR_STL: rdData_q <= stl_q;
        `PMLC_ADDR_XOC: rdData_q <= {xoc_q[15:6], mdixDone_q, mdix_q,
                                     xoc_q[3:0]};
        `PMLC_ADDR_FGC: rdData_q <= {fgc_q[15:2], faultLatched_q,
                                     fgc_q[0]};
        default: rdData_q <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // fiber path and signal detect
  // ----------------------------------------------------------------
  logic bypassTx_q;
  logic bypassRx_q;
  logic linkUp_q;
  logic sdActive;

  assign sdActive = pinF_q[2] ^ fgc_q[`PMLC_FGC_SDPOL];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bypassTx_q <= 1'b0;
      bypassRx_q <= 1'b0;
      faultLatched_q <= 1'b0;
      linkUp_q <= 1'b0;
    end else begin
      bypassTx_q <= fiberMode_q;
      bypassRx_q <= fiberMode_q;
      // a new fault wins over the clearing soft reset
      if (fiberMode_q && !sdEn_q && fiberLinkFault) begin
        faultLatched_q <= 1'b1;
      end else if (softReset_q) begin
        faultLatched_q <= 1'b0;
      end
      linkUp_q <= fiberMode_q && (sdEn_q ? sdActive : !faultLatched_q);
    end
  end

  // ----------------------------------------------------------------
  // crossover, negotiation and speed
  // ----------------------------------------------------------------
  logic [9:0] slot_q;
  logic autoCrossEn;
  logic anEn;
  logic anActive_q;
  logic speed100_q;
  logic polInv_q;
  logic [9:0] slotLen;

  assign autoCrossEn = xoc_q[`PMLC_XOC_AUTO] && !fiberMode_q;
  assign anEn = bmc_q[`PMLC_BMC_ANEN] && !fiberMode_q;
  assign slotLen = gc1_q[`PMLC_GC1_FASTX] ? 10'(`PMLC_XSLOT_FAST) :
                   10'(`PMLC_XSLOT_SLOW);

  // resolution runs whether or not negotiation is on
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      slot_q <= 10'h000;
      mdix_q <= 1'b0;
      mdixDone_q <= 1'b0;
    end else if (!autoCrossEn) begin
      slot_q <= 10'h000;
      mdix_q <= xoc_q[`PMLC_XOC_FORCE];
      mdixDone_q <= 1'b1;
    end else if (energyDetected) begin
      slot_q <= 10'h000;
      mdixDone_q <= 1'b1;
    end else begin
      mdixDone_q <= 1'b0;
      if (slot_q >= slotLen - 10'h001) begin
        slot_q <= 10'h000;
        mdix_q <= ~mdix_q;
      end else begin
        slot_q <= slot_q + 10'h001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      anActive_q <= 1'b0;
      speed100_q <= 1'b1;
      polInv_q <= 1'b0;
    end else begin
      anActive_q <= anEn && mdixDone_q;
      if (fiberMode_q) begin
        speed100_q <= 1'b1;
      end else if (!anEn) begin
        speed100_q <= bmc_q[`PMLC_BMC_SPEED];
      end else if (partnerPageValid && anActive_q &&
                   partnerAbility != 2'h0) begin
        speed100_q <= partnerAbility[1];
      end
      if (speed100_q) begin
        polInv_q <= 1'b0;
      end else if (nlpSeen) begin
        polInv_q <= nlpNegFirst;
      end
    end
  end

  // ----------------------------------------------------------------
  // 10 Mbps link pulses
  // ----------------------------------------------------------------
  logic [18:0] nlpCnt_q;
  logic nlp_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nlpCnt_q <= 19'h00000;
      nlp_q <= 1'b0;
    end else if (speed100_q || fiberMode_q || txEnable) begin
      nlpCnt_q <= 19'h00000;
      nlp_q <= 1'b0;
    end else begin
      nlpCnt_q <= (nlpCnt_q == 19'(NLP_CYC - 1)) ? 19'h00000 :
                  nlpCnt_q + 19'h00001;
      nlp_q <= nlpCnt_q < 19'(`PMLC_NLP_W_CYC);
    end
  end

  // ----------------------------------------------------------------
  // squelch, jabber and loopback outputs
  // ----------------------------------------------------------------
  logic loopMii_q;
  logic [3:0] loopStl_q;

  pmlc_squelch u_squelch (
    .clk(clk),
    .rst_n(rst_n),
    .posCross(pinF_q[1] && !sqPosPrev_q),
    .negCross(pinF_q[0] && !sqNegPrev_q),
    .txActive(txEnable),
    .rxValid(rxDataValid)
  );

  pmlc_jabber #(
    .JAB_CYC(JAB_CYC),
    .UNJAB_CYC(UNJAB_CYC)
  ) u_jabber (
    .clk(clk),
    .rst_n(rst_n),
    .txEnable(txEnable),
    .speed10(!speed100_q),
    .txDisable(txDisable)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      loopMii_q <= 1'b0;
      loopStl_q <= 4'h0;
    end else begin
      loopMii_q <= bmc_q[`PMLC_BMC_LOOPMII];
      loopStl_q <= stl_q[3:0];
    end
  end

  assign mgmtRdData = rdData_q;
  assign txBypassScramble = bypassTx_q;
  assign rxBypassDescramble = bypassRx_q;
  assign fiberSignalDetectEn = sdEn_q;
  assign fiberLinkUp = linkUp_q;
  assign linkPulseOut = nlp_q;
  assign rxPolarityInvert = polInv_q;
  assign autonegActive = anActive_q;
  assign speed100 = speed100_q;
  assign mdixSelect = mdix_q;
  assign loopMii = loopMii_q;
  assign loopPcsIn = loopStl_q[`PMLC_STL_PCSIN];
  assign loopPcsOut = loopStl_q[`PMLC_STL_PCSOUT];
  assign loopDigital = loopStl_q[`PMLC_STL_DIGITAL];
  assign loopAnalog = loopStl_q[`PMLC_STL_ANALOG];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_loop_clear;
    @(posedge clk) disable iff (!rst_n)
      $rose(rst_n) |-> (!loopMii_q && loopStl_q == 4'h0)[*2];
  endproperty
  a_loop_clear: assert property (p_loop_clear)
    else $error("loopback selected right after reset");

  property p_fx_bypass;
    @(posedge clk) disable iff (!rst_n)
      fiberMode_q |=> (bypassTx_q && bypassRx_q);
  endproperty
  a_fx_bypass: assert property (p_fx_bypass)
    else $error("fiber mode without encoder bypass");

  property p_fault_hold;
    @(posedge clk) disable iff (!rst_n)
      (faultLatched_q && !softReset_q) |=> (faultLatched_q && !linkUp_q);
  endproperty
  a_fault_hold: assert property (p_fault_hold)
    else $error("fiber fault cleared without soft reset");

  property p_nlp_width;
    @(posedge clk) disable iff (!rst_n)
      ($rose(nlp_q) && !txEnable && !speed100_q) |=>
        (nlp_q || txEnable) ##1 (!nlp_q);
  endproperty
  a_nlp_width: assert property (p_nlp_width)
    else $error("link pulse width is not two cycles");

  property p_an_after_mdix;
    @(posedge clk) disable iff (!rst_n)
      anActive_q |-> $past(mdixDone_q);
  endproperty
  a_an_after_mdix: assert property (p_an_after_mdix)
    else $error("negotiation started before crossover resolved");

  property p_an_no_fiber;
    @(posedge clk) disable iff (!rst_n)
      $past(fiberMode_q) |-> !anActive_q;
  endproperty
  a_an_no_fiber: assert property (p_an_no_fiber)
    else $error("negotiation active in fiber mode");

  property p_mdix_forced;
    @(posedge clk) disable iff (!rst_n)
      !autoCrossEn |=> mdix_q == $past(xoc_q[`PMLC_XOC_FORCE]);
  endproperty
  a_mdix_forced: assert property (p_mdix_forced)
    else $error("forced pair assignment not applied");

  property p_mii_loop;
    @(posedge clk) disable iff (!rst_n)
      (wrHit(`PMLC_ADDR_BMC) && !loadDefaults &&
       mgmtWrData[`PMLC_BMC_LOOPMII]) |=> ##1 loopMii_q;
  endproperty
  a_mii_loop: assert property (p_mii_loop)
    else $error("interface loopback not selected two cycles after write");
endmodule

/* File: tb/pmlc_partner.sv */
`timescale 1ns/1ns
module pmlc_partner (
  input wire logic clk,
  input wire logic burst,
  input wire logic [2:0] count,
  output logic posCross,
  output logic negCross
);
  int n;
  // alternating crossings, 3 cycles apart, well over the minimum gap;
  // burst is sampled on the rising edge so the request cannot be missed
  initial begin
    posCross = 1'b0;
    negCross = 1'b0;
    forever begin
      @(posedge clk);
      if (burst) begin
        @(negedge clk);
        for (n = 0; n < count; n++) begin
          posCross = (n % 2 == 0);
          negCross = (n % 2 == 1);
          repeat (3) @(negedge clk);
        end
        posCross = 1'b0;
        negCross = 1'b0;
      end
    end
  end
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ns
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic txEnable = 1'b0;
  logic wrEn = 1'b0;
  logic rdEn = 1'b0;
  logic burst = 1'b0;
  logic [1:0] fms = 2'h0;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wd = 16'h0000;
  logic [15:0] rq;
  logic flt = 1'b0;
  logic ns = 1'b0;
  logic nn = 1'b0;
  logic ppv = 1'b0;
  logic [1:0] pa = 2'h0;
  logic [2:0] ncross = 3'h3;
  logic pc, nc, bs, bsr, rv, lp, td, s100, mx, lm, li, lo, ld, la;
  logic sd, lu, pi, an;
  int n_mismatch = 0;
  int check_count = 0;
  int i;
  always #25 clk = ~clk;
  pmlc_partner u_pmlc_partner (.clk(clk), .burst(burst), .count(ncross),
    .posCross(pc), .negCross(nc));
  pmlc_top #(.NLP_CYC(40), .JAB_CYC(50), .UNJAB_CYC(80)) u_pmlc_top (
    .clk(clk), .rst_n(rst_n), .fiberModeStrap(fms),
    .autoCrossoverStrap(2'h0), .autonegStrap(1'b0),
    .fiberSignalDetectPin(1'b0), .fiberLinkFault(flt), .sqPosCross(pc),
    .sqNegCross(nc), .nlpSeen(ns), .nlpNegFirst(nn),
    .txEnable(txEnable), .energyDetected(1'b0), .partnerPageValid(ppv),
    .partnerAbility(pa), .mgmtAddr(addr), .mgmtWrData(wd),
    .mgmtWrEn(wrEn), .mgmtRdEn(rdEn), .mgmtRdData(rq),
    .txBypassScramble(bs), .rxBypassDescramble(bsr),
    .fiberSignalDetectEn(sd), .fiberLinkUp(lu), .rxDataValid(rv),
    .linkPulseOut(lp), .txDisable(td), .rxPolarityInvert(pi),
    .autonegActive(an), .speed100(s100), .mdixSelect(mx), .loopMii(lm),
    .loopPcsIn(li), .loopPcsOut(lo), .loopDigital(ld), .loopAnalog(la));
  task automatic wrap_up;
    if (n_mismatch == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: %h expected %h", $time, s, e);
    end
  endtask
  task automatic rst;
    rst_n = 1'b0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    addr = a;
    wd = d;
    wrEn = 1'b1;
    @(negedge clk);
    wrEn = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    addr = a;
    rdEn = 1'b1;
    @(negedge clk);
    rdEn = 1'b0;
    repeat (2) @(negedge clk);
    chk(rq, e);
  endtask
  task automatic page;
    ppv = 1'b1;
    @(negedge clk);
    ppv = 1'b0;
    @(negedge clk);
  endtask
  task automatic sq_burst(input logic [2:0] c, input logic e);
    ncross = c;
    burst = 1'b1;
    @(negedge clk);
    burst = 1'b0;
    for (i = 0; i < 40 && rv !== 1'b1; i++) @(negedge clk);
    chk(rv, e);
  endtask
  task automatic t_loop;
    chk({lm, li, lo, ld, la}, 16'h0000);
    rd(16'h0016, 16'h0000);
    rd(16'h0123, 16'h0000);
    wr(16'h0000, 16'h2000);
    wr(16'h0019, 16'h0000);
    for (i = 0; i < 4; i++) begin
      wr(16'h0016, 16'h0001 << i);
      chk({la, ld, lo, li}, 16'h0001 << i);
    end
    wr(16'h0016, 16'h0000);
    wr(16'h0000, 16'h6000);
    chk(lm, 1'b1);
    rd(16'h0000, 16'h6000);
    wr(16'h0019, 16'h4000);
    chk(mx, 1'b1);
    wr(16'h0019, 16'h0000);
    chk(mx, 1'b0);
    wr(16'h0000, 16'h1000);
    chk(an, 1'b1);
    pa = 2'h1;
    page();
    chk(s100, 1'b0);
    pa = 2'h3;
    page();
    chk(s100, 1'b1);
  endtask
  task automatic t_jab;
    wr(16'h0000, 16'h0000);
    chk(s100, 1'b0);
    for (i = 0; i < 80; i++) begin
      @(negedge clk);
      wd = wd + lp;
    end
    chk(wd, 16'h0004);
    nn = 1'b1;
    ns = 1'b1;
    @(negedge clk);
    ns = 1'b0;
    nn = 1'b0;
    chk(pi, 1'b1);
    txEnable = 1'b1;
    repeat (40) @(negedge clk);
    chk(td, 1'b0);
    for (i = 0; i < 30 && td !== 1'b1; i++) @(negedge clk);
    chk(td, 1'b1);
    txEnable = 1'b0;
    repeat (70) @(negedge clk);
    chk(td, 1'b1);
    for (i = 0; i < 30 && td !== 1'b0; i++) @(negedge clk);
    chk(td, 1'b0);
  endtask
  task automatic t_sq;
    // under transmit three crossings are not enough; reset clears the
    // half-qualified state before the next burst
    txEnable = 1'b1;
    sq_burst(3'h3, 1'b0);
    rst();
    sq_burst(3'h5, 1'b1);
    txEnable = 1'b0;
    repeat (30) @(negedge clk);
    chk(rv, 1'b0);
    sq_burst(3'h3, 1'b1);
    repeat (30) @(negedge clk);
    chk(rv, 1'b0);
  endtask
  initial begin
    repeat (5000) @(negedge clk);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    rst();
    t_loop();
    t_jab();
    t_sq();
    // level 2 fiber strap only takes effect through a fresh reset
    fms = 2'h1;
    rst();
    chk({bs, bsr, s100, lu, an, sd}, 16'h003c);
    flt = 1'b1;
    @(negedge clk);
    flt = 1'b0;
    rd(16'h0465, 16'h0002);
    chk(lu, 1'b0);
    wr(16'h0000, 16'h8000);
    chk(lu, 1'b1);
    rd(16'h0465, 16'h0000);
    wrap_up();
  end
endmodule
